// ---- rtl/lcd_paged_instruction_decoder.sv ----
// Paged instruction decoder: host strobe interface to instruction registers.
// Assumes host pins are asynchronous; display RAM and frame timing are
// provided outside, with line and frame pulses on the system clock.
`timescale 1ns/1ns
`default_nettype none

module lcd_paged_instruction_decoder
(
  input  wire logic                      clk_sys,
  input  wire logic                      rst_n,
  input  wire logic                      chip_select_n,
  input  wire logic                      command_data_select,
  input  wire logic                      read_strobe_n,
  input  wire logic                      write_strobe_n,
  input  wire logic [7:0]                bus_data_in,
  output logic      [7:0]                bus_data_out,
  output logic                           bus_data_oe,
  input  wire logic                      line_pulse,
  input  wire logic                      frame_pulse,
  input  wire logic [7:0]                display_ram_rdata,
  output logic                           display_ram_we,
  output logic                           display_ram_re,
  output logic      [7:0]                display_ram_wdata,
  output logic      [2:0]                command_page_select,
  output logic                           factory_test_bit,
  output logic      [7:0]                window_first_col,
  output logic      [6:0]                window_first_row,
  output logic      [6:0]                scan_top_row,
  output logic      [6:0]                inversion_group_length,
  output paged_decoder_pkg::display_ctl_s display_ctl,
  output logic                           drive_ground_level,
  output logic                           ac_polarity_toggle,
  output logic      [3:0]                first_common_index,
  output logic                           duty_minus_one,
  output logic                           display_clock_gate,
  output logic                           gray_mod_fixed,
  output logic                           reduced_color_select,
  output logic                           bit_order_select,
  output logic                           oscillator_source,
  output logic                           bus_width_select,
  output logic      [6:0]                contrast_level,
  output logic      [2:0]                osc_freq_trim,
  output logic                           bleed_off_enable,
  output logic      [7:0]                window_last_col,
  output logic      [6:0]                window_last_row,
  output logic      [6:0]                band_first_row,
  output logic      [6:0]                band_final_row,
  output logic                           band_invert_enable,
  output logic                           blink_select,
  output logic                           palette_bank_select,
  output logic      [3:0]                gray_mod_mode
);

  ////////////////////////////////////////////////////////////////////////////
  // State

  typedef struct packed {
    paged_decoder_pkg::host_pins_s sync1;
    paged_decoder_pkg::host_pins_s sync2;
    paged_decoder_pkg::bus_state_e st;
    logic                          cmd;
    logic [7:0]                    wbyte;
    logic [15:0][3:0]              p0;
    logic [15:0][3:0]              p4;
    logic [15:0][3:0]              p5;
    logic [3:0]                    page_reg;
    logic [6:0]                    contrast;
    logic                          con_hi_seen;
    logic [6:0]                    grp_cnt;
    logic                          ac_pol;
    logic [7:0]                    rdata;
    logic                          oe;
    logic                          ram_we;
    logic                          ram_re;
  } state_s;

  state_s state_reg;
  state_s state_next;

  paged_decoder_pkg::host_pins_s pins;
  logic [2:0]                    pg;
  logic [3:0]                    ra;
  logic [3:0]                    rd_ptr;
  logic [3:0]                    rd_nib;
  logic [6:0]                    grp_len;

  assign pins = '{cs_n: chip_select_n, cd_sel: command_data_select,
                  rd_n: read_strobe_n, wr_n: write_strobe_n,
                  data: bus_data_in};
  assign pg      = state_reg.page_reg[2:0];
  assign ra      = state_reg.wbyte[7:4];
  assign rd_ptr  = state_reg.p4[paged_decoder_pkg::ADDR_P4_RDPTR];
  assign grp_len = {state_reg.p0[paged_decoder_pkg::ADDR_P0_INV_HI][2:0],
                    state_reg.p0[paged_decoder_pkg::ADDR_P0_INV_LO]};

  ////////////////////////////////////////////////////////////////////////////
  // Register read mux: pointer picks a register of the active page

  always_comb
  begin
    rd_nib = paged_decoder_pkg::REG_RESET;
    if (rd_ptr == paged_decoder_pkg::ADDR_PAGE_SEL)
    begin
      rd_nib = state_reg.page_reg;
    end
    else if (pg == paged_decoder_pkg::PAGE_ZERO)
    begin
      rd_nib = state_reg.p0[rd_ptr];
    end
    else if (pg == paged_decoder_pkg::PAGE_FOUR)
    begin
      rd_nib = state_reg.p4[rd_ptr];
    end
    else if (pg == paged_decoder_pkg::PAGE_FIVE)
    begin
      rd_nib = state_reg.p5[rd_ptr];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb
  begin
    state_next        = state_reg;
    state_next.sync1  = pins;
    state_next.sync2  = state_reg.sync1;
    state_next.ram_we = 1'b0;
    state_next.ram_re = 1'b0;

    case (state_reg.st)
      paged_decoder_pkg::ST_IDLE:
      begin
        if (!state_reg.sync2.cs_n && !state_reg.sync2.wr_n)
        begin
          state_next.st = paged_decoder_pkg::ST_WRITE;
        end
        else if (!state_reg.sync2.cs_n && !state_reg.sync2.rd_n)
        begin
          state_next.st  = paged_decoder_pkg::ST_READ;
          state_next.oe  = 1'b1;
          state_next.cmd = state_reg.sync2.cd_sel;
          // Register read returns the pointed register, not RAM
          if (state_reg.sync2.cd_sel)
          begin
            state_next.rdata = {4'h0, rd_nib};
          end
          else
          begin
            // Hands back the word fetched earlier, hence one dummy read
            state_next.rdata  = display_ram_rdata;
            state_next.ram_re = 1'b1;
          end
        end
      end
      paged_decoder_pkg::ST_WRITE:
      begin
        // Byte is sampled continuously and committed on the rising strobe
        state_next.wbyte = state_reg.sync2.data;
        state_next.cmd   = state_reg.sync2.cd_sel;
        if (state_reg.sync2.wr_n || state_reg.sync2.cs_n)
        begin
          state_next.st = paged_decoder_pkg::ST_IDLE;
          if (state_reg.cmd)
          begin
            if (ra == paged_decoder_pkg::ADDR_PAGE_SEL)
            begin
              // Takes effect from the next byte on
              state_next.page_reg = state_reg.wbyte[3:0];
            end
            else if (pg == paged_decoder_pkg::PAGE_ZERO)
            begin
              state_next.p0[ra] = state_reg.wbyte[3:0];
            end
            else if (pg == paged_decoder_pkg::PAGE_FOUR)
            begin
              state_next.p4[ra] = state_reg.wbyte[3:0];
              if (ra == paged_decoder_pkg::ADDR_P4_CON_HI)
              begin
                state_next.con_hi_seen = 1'b1;
              end
              else if (ra == paged_decoder_pkg::ADDR_P4_CON_LO &&
                       state_reg.con_hi_seen)
              begin
                // Upper byte came first; now both are in
                state_next.contrast =
                  {state_reg.p4[paged_decoder_pkg::ADDR_P4_CON_HI][2:0],
                   state_reg.wbyte[3:0]};
                state_next.con_hi_seen = 1'b0;
              end
            end
            else if (pg == paged_decoder_pkg::PAGE_FIVE)
            begin
              state_next.p5[ra] = state_reg.wbyte[3:0];
            end
          end
          else
          begin
            state_next.ram_we = 1'b1;
          end
        end
      end
      paged_decoder_pkg::ST_READ:
      begin
        if (state_reg.sync2.rd_n || state_reg.sync2.cs_n)
        begin
          state_next.st = paged_decoder_pkg::ST_IDLE;
          state_next.oe = 1'b0;
        end
      end
      default:
      begin
        state_next.st = paged_decoder_pkg::ST_IDLE;
      end
    endcase

    // Polarity: per N lines when grouping is on, else per frame
    if (state_reg.p0[paged_decoder_pkg::ADDR_P0_DCTL2]
        [paged_decoder_pkg::DC2_GROUP_INVERSION_ENABLE_BIT])
    begin
      if (line_pulse)
      begin
        // Count value+1 lines per group; zero is illegal from the host
        if (state_reg.grp_cnt >= grp_len)
        begin
          state_next.grp_cnt = 7'h00;
          state_next.ac_pol  = ~state_reg.ac_pol;
        end
        else
        begin
          state_next.grp_cnt = state_reg.grp_cnt + 7'h01;
        end
      end
    end
    else if (frame_pulse)
    begin
      state_next.grp_cnt = 7'h00;
      state_next.ac_pol  = ~state_reg.ac_pol;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      state_reg          <= '0;
      state_reg.sync1    <= '{cs_n: 1'b1, cd_sel: 1'b0, rd_n: 1'b1,
                              wr_n: 1'b1, data: 8'h00};
      state_reg.sync2    <= '{cs_n: 1'b1, cd_sel: 1'b0, rd_n: 1'b1,
                              wr_n: 1'b1, data: 8'h00};
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign bus_data_out      = state_reg.rdata;
  assign bus_data_oe       = state_reg.oe;
  assign display_ram_we    = state_reg.ram_we;
  assign display_ram_re    = state_reg.ram_re;
  assign display_ram_wdata = state_reg.wbyte;

  assign command_page_select = state_reg.page_reg[2:0];
  // Kept visible only; the host must leave it clear
  assign factory_test_bit =
    state_reg.page_reg[paged_decoder_pkg::PGS_TEST_BIT];

  assign window_first_col = {state_reg.p0[paged_decoder_pkg::ADDR_P0_COL_HI],
                             state_reg.p0[paged_decoder_pkg::ADDR_P0_COL_LO]};
  assign window_first_row =
    {state_reg.p0[paged_decoder_pkg::ADDR_P0_ROW_HI][2:0],
     state_reg.p0[paged_decoder_pkg::ADDR_P0_ROW_LO]};
  assign scan_top_row =
    {state_reg.p0[paged_decoder_pkg::ADDR_P0_SCAN_HI][2:0],
     state_reg.p0[paged_decoder_pkg::ADDR_P0_SCAN_LO]};
  assign inversion_group_length = grp_len;

  always_comb
  begin
    display_ctl.display_on = state_reg.p0[paged_decoder_pkg::ADDR_P0_DCTL1]
                             [paged_decoder_pkg::DC1_ON_BIT];
    display_ctl.force_all_pixels =
      state_reg.p0[paged_decoder_pkg::ADDR_P0_DCTL1]
      [paged_decoder_pkg::DC1_FORCE_ALL_PIXELS_BIT];
    display_ctl.black_white_select =
      state_reg.p0[paged_decoder_pkg::ADDR_P0_DCTL1]
      [paged_decoder_pkg::DC1_BW_BIT];
    display_ctl.common_reverse =
      state_reg.p0[paged_decoder_pkg::ADDR_P0_DCTL1]
      [paged_decoder_pkg::DC1_SHIFT_BIT];
    display_ctl.palette_swap =
      state_reg.p0[paged_decoder_pkg::ADDR_P0_DCTL2]
      [paged_decoder_pkg::DC2_SWAP_BIT];
    // All-on wins, so invert is masked while it is set
    display_ctl.polarity_invert =
      state_reg.p0[paged_decoder_pkg::ADDR_P0_DCTL2]
      [paged_decoder_pkg::DC2_REV_BIT] &
      ~display_ctl.force_all_pixels;
    display_ctl.group_inversion_enable =
      state_reg.p0[paged_decoder_pkg::ADDR_P0_DCTL2]
      [paged_decoder_pkg::DC2_GROUP_INVERSION_ENABLE_BIT];
  end

  assign drive_ground_level = ~display_ctl.display_on;
  assign ac_polarity_toggle = state_reg.ac_pol;

  assign first_common_index  = state_reg.p4[paged_decoder_pkg::ADDR_P4_FIRSTCOM];
  assign duty_minus_one      = state_reg.p4[paged_decoder_pkg::ADDR_P4_DUTY][0];
  assign display_clock_gate  = state_reg.p4[paged_decoder_pkg::ADDR_P4_DUTY][1];
  assign gray_mod_fixed      = state_reg.p4[paged_decoder_pkg::ADDR_P4_MODE][3];
  assign reduced_color_select = state_reg.p4[paged_decoder_pkg::ADDR_P4_MODE][2];
  assign bit_order_select    = state_reg.p4[paged_decoder_pkg::ADDR_P4_BUS][2];
  assign oscillator_source   = state_reg.p4[paged_decoder_pkg::ADDR_P4_BUS][1];
  assign bus_width_select    = state_reg.p4[paged_decoder_pkg::ADDR_P4_BUS][0];
  assign contrast_level      = state_reg.contrast;
  assign osc_freq_trim = state_reg.p4[paged_decoder_pkg::ADDR_P4_TRIM][2:0];
  assign bleed_off_enable = state_reg.p4[paged_decoder_pkg::ADDR_P4_BLEED][0];

  assign window_last_col =
    {state_reg.p5[paged_decoder_pkg::ADDR_P5_LCOL_HI],
     state_reg.p5[paged_decoder_pkg::ADDR_P5_LCOL_LO]};
  assign window_last_row =
    {state_reg.p5[paged_decoder_pkg::ADDR_P5_LROW_HI][2:0],
     state_reg.p5[paged_decoder_pkg::ADDR_P5_LROW_LO]};
  assign band_first_row =
    {state_reg.p5[paged_decoder_pkg::ADDR_P5_BF_HI][2:0],
     state_reg.p5[paged_decoder_pkg::ADDR_P5_BF_LO]};
  assign band_final_row =
    {state_reg.p5[paged_decoder_pkg::ADDR_P5_BL_HI][2:0],
     state_reg.p5[paged_decoder_pkg::ADDR_P5_BL_LO]};
  assign band_invert_enable  = state_reg.p5[paged_decoder_pkg::ADDR_P5_BAND][0];
  assign blink_select        = state_reg.p5[paged_decoder_pkg::ADDR_P5_BAND][1];
  assign palette_bank_select = state_reg.p5[paged_decoder_pkg::ADDR_P5_PAL][0];
  assign gray_mod_mode       = state_reg.p5[paged_decoder_pkg::ADDR_P5_PWM];

endmodule
`default_nettype wire

// ---- rtl/paged_decoder_pkg.sv ----
// Shared constants and carriers for the paged instruction decoder.
// Assumes an 8-bit host data bus and a single system clock.
package paged_decoder_pkg;

  // Register addresses within a page
  localparam logic [3:0] ADDR_P0_COL_LO   = 4'h0;
  localparam logic [3:0] ADDR_P0_COL_HI   = 4'h1;
  localparam logic [3:0] ADDR_P0_ROW_LO   = 4'h2;
  localparam logic [3:0] ADDR_P0_ROW_HI   = 4'h3;
  localparam logic [3:0] ADDR_P0_SCAN_LO  = 4'h4;
  localparam logic [3:0] ADDR_P0_SCAN_HI  = 4'h5;
  localparam logic [3:0] ADDR_P0_INV_LO   = 4'h6;
  localparam logic [3:0] ADDR_P0_INV_HI   = 4'h7;
  localparam logic [3:0] ADDR_P0_DCTL1    = 4'h8;
  localparam logic [3:0] ADDR_P0_DCTL2    = 4'h9;
  localparam logic [3:0] ADDR_P4_FIRSTCOM = 4'h6;
  localparam logic [3:0] ADDR_P4_DUTY     = 4'h7;
  localparam logic [3:0] ADDR_P4_MODE     = 4'h8;
  localparam logic [3:0] ADDR_P4_BUS      = 4'h9;
  localparam logic [3:0] ADDR_P4_CON_LO   = 4'ha;
  localparam logic [3:0] ADDR_P4_CON_HI   = 4'hb;
  localparam logic [3:0] ADDR_P4_RDPTR    = 4'hc;
  localparam logic [3:0] ADDR_P4_TRIM     = 4'hd;
  localparam logic [3:0] ADDR_P4_BLEED    = 4'he;
  localparam logic [3:0] ADDR_P5_LCOL_LO  = 4'h0;
  localparam logic [3:0] ADDR_P5_LCOL_HI  = 4'h1;
  localparam logic [3:0] ADDR_P5_LROW_LO  = 4'h2;
  localparam logic [3:0] ADDR_P5_LROW_HI  = 4'h3;
  localparam logic [3:0] ADDR_P5_BF_LO    = 4'h4;
  localparam logic [3:0] ADDR_P5_BF_HI    = 4'h5;
  localparam logic [3:0] ADDR_P5_BL_LO    = 4'h6;
  localparam logic [3:0] ADDR_P5_BL_HI    = 4'h7;
  localparam logic [3:0] ADDR_P5_BAND     = 4'h8;
  localparam logic [3:0] ADDR_P5_PAL      = 4'h9;
  localparam logic [3:0] ADDR_P5_PWM      = 4'ha;
  localparam logic [3:0] ADDR_PAGE_SEL    = 4'hf;

  localparam logic [2:0] PAGE_ZERO = 3'h0;
  localparam logic [2:0] PAGE_FOUR = 3'h4;
  localparam logic [2:0] PAGE_FIVE = 3'h5;
  localparam logic [3:0] REG_RESET = 4'h0;

  // Field positions
  localparam int DC1_ON_BIT    = 0;
  localparam int DC1_FORCE_ALL_PIXELS_BIT = 1;
  localparam int DC1_BW_BIT    = 2;
  localparam int DC1_SHIFT_BIT = 3;
  localparam int DC2_SWAP_BIT  = 1;
  localparam int DC2_GROUP_INVERSION_ENABLE_BIT  = 2;
  localparam int DC2_REV_BIT   = 3;
  localparam int PGS_TEST_BIT  = 3;

  typedef struct packed {
    logic       cs_n;
    logic       cd_sel;
    logic       rd_n;
    logic       wr_n;
    logic [7:0] data;
  } host_pins_s;

  typedef struct packed {
    logic       display_on;
    logic       force_all_pixels;
    logic       black_white_select;
    logic       common_reverse;
    logic       palette_swap;
    logic       polarity_invert;
    logic       group_inversion_enable;
  } display_ctl_s;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_WRITE = 2'b01,
    ST_READ  = 2'b10
  } bus_state_e;

endpackage

// ---- dv/decoder_asserts.sv ----
// Checker for the paged instruction decoder, bound to its top module.
// Assumes host strobes stay low and high for several clocks each.
`timescale 1ns/1ns
`default_nettype none
module decoder_asserts
(
  input wire logic                            clk_sys,
  input wire logic                            rst_n,
  input wire logic                            read_strobe_n,
  input wire logic                            write_strobe_n,
  input wire logic                            line_pulse,
  input wire logic                            frame_pulse,
  input wire logic                            bus_data_oe,
  input wire logic                            display_ram_we,
  input wire logic                            display_ram_re,
  input wire paged_decoder_pkg::display_ctl_s display_ctl,
  input wire logic                            drive_ground_level,
  input wire logic                            ac_polarity_toggle,
  input wire logic [2:0]                      command_page_select,
  input wire logic [6:0]                      contrast_level
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);
  //////////////////////////////////////////////////////////////////////////
  a_ground_follow: assert property (
    drive_ground_level == !display_ctl.display_on)
    else $error("ground level does not follow display on");
  a_invert_masked: assert property (
    display_ctl.force_all_pixels |-> !display_ctl.polarity_invert)
    else $error("polarity invert not masked by force all");
  a_ram_write: assert property (
    display_ram_we |-> $past(write_strobe_n, 5) == 1'b0 ##1 !display_ram_we)
    else $error("display write pulse without strobe or too long");
  a_ram_read: assert property (
    display_ram_re |-> $past(read_strobe_n, 2) == 1'b0 ##1 !display_ram_re)
    else $error("display read pulse without strobe or too long");
  a_oe_rise: assert property (
    $rose(bus_data_oe) |-> $past(read_strobe_n, 2) == 1'b0)
    else $error("bus driven without read strobe");
  a_oe_drop: assert property (
    $rose(read_strobe_n) |-> ##[1:5] !bus_data_oe)
    else $error("bus still driven after read ends");
  // Contrast may only move on a write taken while page four is active
  a_contrast_src: assert property (
    $changed(contrast_level) |-> $past(write_strobe_n, 5) == 1'b0
      && $past(command_page_select, 4) == 3'h4)
    else $error("contrast changed without page four write");
  a_page_src: assert property (
    $changed(command_page_select) |-> $past(write_strobe_n, 5) == 1'b0)
    else $error("page changed without a write");
  a_ac_source: assert property (
    $changed(ac_polarity_toggle) |-> $past(line_pulse) || $past(frame_pulse)
      || $past(line_pulse, 2) || $past(frame_pulse, 2))
    else $error("polarity toggled without line or frame pulse");
endmodule

bind lcd_paged_instruction_decoder decoder_asserts decoder_asserts_inst (.*);
`default_nettype wire

// ---- dv/host_model.sv ----
// Host processor model driving the decoder's strobe bus.
// Assumes the decoder synchronises pins; strobes are held five clocks.
`timescale 1ns/1ns
`default_nettype none
module host_model
(
  input  wire logic       clk_sys,
  output logic            chip_select_n,
  output logic            command_data_select,
  output logic            read_strobe_n,
  output logic            write_strobe_n,
  output logic [7:0]      bus_data_in,
  input  wire logic [7:0] bus_data_out,
  input  wire logic       bus_data_oe
);
  initial
  begin
    chip_select_n = 1'b1;
    command_data_select = 1'b1;
    read_strobe_n = 1'b1;
    write_strobe_n = 1'b1;
    bus_data_in = 8'h00;
  end
  // Callers send low nibble first except contrast (upper first), test bit zero
  task automatic wr(input logic cd, input logic [7:0] d);
    @(negedge clk_sys);
    chip_select_n = 1'b0;
    command_data_select = cd;
    bus_data_in = d;
    write_strobe_n = 1'b0;
    repeat (5) @(negedge clk_sys);
    write_strobe_n = 1'b1;
    // Data held past the commit edge, then scrambled like a released bus
    repeat (4) @(negedge clk_sys);
    chip_select_n = 1'b1;
    bus_data_in = ~d;
    repeat (2) @(negedge clk_sys);
  endtask
  task automatic rd(input logic cd, output logic [7:0] q);
    @(negedge clk_sys);
    chip_select_n = 1'b0;
    command_data_select = cd;
    read_strobe_n = 1'b0;
    repeat (5) @(negedge clk_sys);
    q = bus_data_oe ? bus_data_out : 8'hxx;
    read_strobe_n = 1'b1;
    repeat (5) @(negedge clk_sys);
    chip_select_n = 1'b1;
  endtask
endmodule
`default_nettype wire

// ---- dv/test_lcd_paged_instruction_decoder.sv ----
// Self-checking bench: host model drives register and display traffic.
// Assumes a 100 MHz clock and the decoder's two-flop pin synchroniser.
`timescale 1ns/1ns
`default_nettype none
module test_lcd_paged_instruction_decoder;
  logic       clk_sys, rst_n, chip_select_n, command_data_select;
  logic       read_strobe_n, write_strobe_n, bus_data_oe, line_pulse;
  logic       frame_pulse, display_ram_we, display_ram_re, factory_test_bit;
  logic       drive_ground_level, ac_polarity_toggle, duty_minus_one, ac_prev;
  logic       display_clock_gate, gray_mod_fixed, reduced_color_select;
  logic       bit_order_select, oscillator_source, bus_width_select;
  logic       bleed_off_enable, band_invert_enable, blink_select;
  logic       palette_bank_select;
  logic [2:0] command_page_select, osc_freq_trim;
  logic [3:0] first_common_index, gray_mod_mode;
  logic [6:0] window_first_row, scan_top_row, inversion_group_length;
  logic [6:0] contrast_level, window_last_row, band_first_row, band_final_row;
  logic [7:0] bus_data_in, bus_data_out, display_ram_wdata, window_first_col;
  logic [7:0] window_last_col, rd_q, we_data, display_ram_rdata;
  int         err_total, n_tests, flips, f0, we_cnt, re_cnt;
  paged_decoder_pkg::display_ctl_s display_ctl;
  //////////////////////////////////////////////////////////////////////////
  lcd_paged_instruction_decoder lcd_paged_instruction_decoder_inst (.*);
  host_model host_model_inst (.*);
  //////////////////////////////////////////////////////////////////////////
  initial
  begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys)
  begin
    ac_prev <= ac_polarity_toggle;
    if (rst_n && ac_polarity_toggle !== ac_prev)
      flips <= flips + 1;
    if (display_ram_we === 1'b1)
    begin
      we_cnt <= we_cnt + 1;
      we_data <= display_ram_wdata;
    end
    // RAM stand-in: each read advances to the last written byte
    if (display_ram_re === 1'b1)
    begin
      re_cnt <= re_cnt + 1;
      display_ram_rdata <= we_data;
    end
  end
  task automatic check(input string what, input logic [7:0] seen,
                       input logic [7:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic cw(input logic [7:0] b);
    host_model_inst.wr(1'b1, b);
  endtask
  task automatic pulses(input int n, input logic frm);
    repeat (n)
    begin
      @(negedge clk_sys);
      line_pulse = !frm;
      frame_pulse = frm;
      @(negedge clk_sys);
      line_pulse = 1'b0;
      frame_pulse = 1'b0;
      repeat (2) @(negedge clk_sys);
    end
  endtask
  task automatic results();
    $display("comparisons %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // Whole sequence needs about 600 cycles; generous margin
  initial
  begin
    #200000;
    err_total++;
    results();
  end
  //////////////////////////////////////////////////////////////////////////
  initial
  begin
    err_total = 0;
    n_tests = 0;
    flips = 0;
    we_cnt = 0;
    re_cnt = 0;
    display_ram_rdata = 8'hc3;
    rst_n = 1'b0;
    line_pulse = 1'b0;
    frame_pulse = 1'b0;
    repeat (10) @(negedge clk_sys);
    rst_n = 1'b1;
    repeat (2) @(negedge clk_sys);
    check("ground", {7'h0, drive_ground_level}, 8'h01);
    check("page", {4'h0, factory_test_bit, command_page_select},
          8'h00);
    check("first col", window_first_col, 8'h00);
    $display("test reset done");
    cw(8'h05);
    check("col low only", window_first_col, 8'h05);
    cw(8'h1a);
    check("first col", window_first_col, 8'ha5);
    cw(8'h2f);
    cw(8'h37);
    check("first row", {1'b0, window_first_row}, 8'h7f);
    cw(8'h43);
    cw(8'h56);
    check("scan top", {1'b0, scan_top_row}, 8'h63);
    cw(8'h62);
    cw(8'h70);
    check("group", {1'b0, inversion_group_length}, 8'h02);
    cw(8'h8b);
    cw(8'h9e);
    check("ctl all on", {1'b0, display_ctl}, 8'h6d);
    cw(8'h89);
    check("ctl invert", {1'b0, display_ctl}, 8'h4f);
    cw(8'h84);
    check("ctl mono off", {1'b0, display_ctl}, 8'h17);
    check("ground off", {7'h0, drive_ground_level}, 8'h01);
    $display("test page zero done");
    cw(8'hf4);
    check("page four", {5'h0, command_page_select}, 8'h04);
    cw(8'h69);
    cw(8'h73);
    cw(8'h8c);
    cw(8'h95);
    cw(8'hd5);
    cw(8'he1);
    check("first com", {4'h0, first_common_index}, 8'h09);
    check("duty", {6'h0, display_clock_gate, duty_minus_one}, 8'h03);
    check("mode", {6'h0, gray_mod_fixed, reduced_color_select}, 8'h03);
    check("bus cfg", {5'h0, bit_order_select, oscillator_source,
          bus_width_select}, 8'h05);
    check("trim", {5'h0, osc_freq_trim}, 8'h05);
    check("bleed", {7'h0, bleed_off_enable}, 8'h01);
    cw(8'hb5);
    check("contrast upper", {1'b0, contrast_level}, 8'h00);
    cw(8'ha3);
    check("contrast", {1'b0, contrast_level}, 8'h53);
    cw(8'ha7);
    check("contrast lone", {1'b0, contrast_level}, 8'h53);
    cw(8'hc6);
    host_model_inst.rd(1'b1, rd_q);
    check("read first com", rd_q, 8'h09);
    cw(8'hcf);
    host_model_inst.rd(1'b1, rd_q);
    check("read page", rd_q, 8'h04);
    $display("test page four done");
    cw(8'hf5);
    cw(8'h0c);
    cw(8'h13);
    cw(8'h21);
    cw(8'h36);
    cw(8'h42);
    cw(8'h51);
    cw(8'h64);
    cw(8'h77);
    cw(8'h82);
    cw(8'h91);
    cw(8'haa);
    check("last col", window_last_col, 8'h3c);
    check("last row", {1'b0, window_last_row}, 8'h61);
    check("band first", {1'b0, band_first_row}, 8'h12);
    check("band final", {1'b0, band_final_row}, 8'h74);
    check("band ctl", {6'h0, blink_select, band_invert_enable}, 8'h02);
    check("palette", {7'h0, palette_bank_select}, 8'h01);
    check("gray mode", {4'h0, gray_mod_mode}, 8'h0a);
    $display("test page five done");
    cw(8'hf1);
    check("page one", {5'h0, command_page_select}, 8'h01);
    cw(8'h07);
    host_model_inst.wr(1'b0, 8'h5a);
    check("ram data", we_data, 8'h5a);
    check("ram writes", 8'(we_cnt), 8'h01);
    host_model_inst.rd(1'b0, rd_q);
    check("ram dummy", rd_q, 8'hc3);
    host_model_inst.rd(1'b0, rd_q);
    check("ram read", rd_q, 8'h5a);
    check("ram reads", 8'(re_cnt), 8'h02);
    cw(8'hf0);
    check("col kept", window_first_col, 8'ha5);
    $display("test data done");
    cw(8'h94);
    f0 = flips;
    pulses(6, 1'b0);
    check("group flips", 8'(flips - f0), 8'h02);
    cw(8'h90);
    f0 = flips;
    pulses(3, 1'b1);
    check("frame flips", 8'(flips - f0), 8'h03);
    $display("test polarity done");
    rst_n = 1'b0;
    repeat (2) @(negedge clk_sys);
    rst_n = 1'b1;
    @(negedge clk_sys);
    check("page rerst", {5'h0, command_page_select}, 8'h00);
    check("contrast rerst", {1'b0, contrast_level}, 8'h00);
    $display("test second reset done");
    results();
  end
endmodule
`default_nettype wire
